// File: logic/bwid_pkg.sv
// constants for the bandwidth feature identification register bank
// Functional notes
// - The partition word reads at 0x0040 in all four space frames and is read-only.
// - Every space has its own copy of each word, with equal or different contents.
// - With instance selection, instance fields follow the selected instance, others stay fixed.
// - The monitor word exists only with monitoring and usage monitoring, else reads zero.
// - Bit 31 reads 1 only when a capture event can copy the counter to a snapshot register.
// - Bit 30 reports the wide counter, which with bit 31 set also has a wide snapshot.
// - Bit 29 picks a 44-bit or 63-bit wide count and must read 0 when no wide counter exists.
// - Bit 28 reads 1 only when the usage filter can select read, write or both kinds of traffic.
// - Bit 27 reads 1 only when the control register offers the overflow linkage field.
// - Bit 26 reads 1 only when the usage overflow bitmap register is implemented.
// - Bit 25 reads 1 only when a capture event may trigger overflow actions.
// - Bit 24 reads 1 only when the control register lets an overflow capture the counter.
// - Bits 20 to 16 give the counter right-shift scaling, zero meaning no scaling.
// - Bits 15 to 0 give the usage monitor instance count, the top selector being one less.
// - Each space copy reports the count of monitor instances available to that space.
package bwid_pkg;

    // ==========================================================
    // register offsets inside one feature frame
    localparam logic [15:0] BWID_PART_FEAT_OFS = 16'h0040;
    localparam logic [15:0] BWID_MON_FEAT_OFS  = 16'h0090;

    // ==========================================================
    // security spaces, one feature frame each
    localparam int          BWID_NUM_SPACES    = 4;
    localparam logic [1:0]  BWID_SPACE_SECURE  = 2'h0;
    localparam logic [1:0]  BWID_SPACE_NONSEC  = 2'h1;
    localparam logic [1:0]  BWID_SPACE_ROOT    = 2'h2;
    localparam logic [1:0]  BWID_SPACE_REALM   = 2'h3;

    // ==========================================================
    // usage monitor feature word field positions
    localparam int BWID_CAPT_BIT    = 31;
    localparam int BWID_LONG_BIT    = 30;
    localparam int BWID_WSEL_BIT    = 29;
    localparam int BWID_RWBW_BIT    = 28;
    localparam int BWID_LNKG_BIT    = 27;
    localparam int BWID_OFSR_BIT    = 26;
    localparam int BWID_CEVNT_BIT   = 25;
    localparam int BWID_OFCAPT_BIT  = 24;
    localparam int BWID_SCALE_LSB   = 16;
    localparam int BWID_SCALE_W     = 5;
    localparam int BWID_COUNT_LSB   = 0;
    localparam int BWID_COUNT_W     = 16;

    // ==========================================================
    // partition feature word: bits that exist (others reserved)
    localparam logic [31:0] BWID_PART_VALID_MASK = 32'h1fff_7c3f;

    // ==========================================================
    // reset values of the read port
    localparam logic [31:0] BWID_RDATA_RST = 32'h0000_0000;

endpackage : bwid_pkg

// File: logic/bwid_mon_word.sv
// assembles one usage monitor feature word from its capability flags
`timescale 1ns/1ps
`default_nettype none
module bwid_mon_word
    import bwid_pkg::*;
(
    input  wire logic                    present,
    input  wire logic                    ext_present,
    input  wire logic                    capt,
    input  wire logic                    long_ctr,
    input  wire logic                    wide_sel,
    input  wire logic                    rwbw,
    input  wire logic                    lnkg,
    input  wire logic                    ofsr,
    input  wire logic                    cevnt,
    input  wire logic                    ofcapt,
    input  wire logic [BWID_SCALE_W-1:0] scale,
    input  wire logic [BWID_COUNT_W-1:0] count,
    output logic      [31:0]             word
);

    // ==========================================================
    // field packing
    // extension-only flags are forced low when the extension is absent
    always_comb begin
        word = 32'h0000_0000;
        if (present) begin
            word[BWID_CAPT_BIT]   = capt;
            word[BWID_LONG_BIT]   = ext_present & long_ctr;
            word[BWID_WSEL_BIT]   = ext_present & long_ctr & wide_sel;
            word[BWID_RWBW_BIT]   = ext_present & rwbw;
            word[BWID_LNKG_BIT]   = ext_present & lnkg;
            word[BWID_OFSR_BIT]   = ext_present & ofsr;
            word[BWID_CEVNT_BIT]  = cevnt;
            word[BWID_OFCAPT_BIT] = ext_present & ofcapt;
            word[BWID_SCALE_LSB +: BWID_SCALE_W] = scale;
            word[BWID_COUNT_LSB +: BWID_COUNT_W] = count;
        end
    end

endmodule : bwid_mon_word
`default_nettype wire

// File: logic/bwid_feature_regs.sv
// read-only bandwidth partition and usage monitor feature registers, all spaces
`timescale 1ns/1ps
`default_nettype none
module bwid_feature_regs
    import bwid_pkg::*;
#(
    parameter int                              SEL_W       = 1,
    parameter int                              NUM_INST    = 1,
    parameter int                              ADDR_W      = 16,
    parameter logic                            SEL_PRESENT = 1'b0,
    parameter logic                            EXT_PRESENT = 1'b1,
    parameter logic [NUM_INST-1:0]             MSMON_PRES  = '1,
    parameter logic [NUM_INST-1:0]             MBWU_PRES   = '1,
    parameter logic [NUM_INST-1:0]             CAPT        = '1,
    parameter logic [NUM_INST-1:0]             LONG_CTR    = '1,
    parameter logic [NUM_INST-1:0]             WIDE_SEL    = '0,
    parameter logic [NUM_INST-1:0]             RWBW        = '0,
    parameter logic [NUM_INST-1:0]             LNKG        = '0,
    parameter logic [NUM_INST-1:0]             OFSR        = '0,
    parameter logic [NUM_INST-1:0]             CEVNT       = '0,
    parameter logic [NUM_INST-1:0]             OFCAPT      = '0,
    parameter logic [NUM_INST*5-1:0]           SCALE       = '0,
    parameter logic [4*NUM_INST*16-1:0]        MON_COUNT   = {4*NUM_INST{16'h0004}},
    parameter logic [4*NUM_INST*32-1:0]        PART_WORD   = {4*NUM_INST{32'h0000_0c08}}
)
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    input  wire logic              rd_req,
    input  wire logic              wr_req,
    input  wire logic [1:0]        space,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wr_data,
    input  wire logic [SEL_W-1:0]  resource_instance_selector,
    output logic      [31:0]       rd_data,
    output logic                   rd_ack,
    output logic                   wr_ack
);

    // ==========================================================
    // elaboration checks
    generate
        if (NUM_INST < 1 || NUM_INST > (1 << SEL_W)) begin : g_bad_inst
            $error("NUM_INST must be 1 to 2**SEL_W");
        end
        if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr
            $error("ADDR_W must be 8 to 16");
        end
    endgenerate

    // ==========================================================
    // offset match, port address zero-extended to the 16-bit offset width
    function automatic logic ofs_hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
        logic [15:0] wide;
        wide = 16'h0000;
        wide[ADDR_W-1:0] = a;
        ofs_hit = (wide == ofs);
    endfunction : ofs_hit

    // ==========================================================
    // instance in force: selector when instance selection exists, else 0
    logic [SEL_W-1:0] inst;
    logic             inst_ok;
    logic [31:0]      inst_idx;
    logic [31:0]      slot_idx;

    // out-of-range selectors read as an absent instance, never alias
    always_comb begin
        inst     = SEL_PRESENT ? resource_instance_selector : '0;
        inst_ok  = (32'(inst) < 32'(NUM_INST));
        inst_idx = inst_ok ? 32'(inst) : 32'h0000_0000;
        slot_idx = 32'(space) * 32'(NUM_INST) + inst_idx;
    end

    // ==========================================================
    // per-space, per-instance usage monitor word
    logic [31:0] mon_word;
    logic        mon_present;

    assign mon_present = inst_ok & MSMON_PRES[inst_idx] & MBWU_PRES[inst_idx];

    bwid_mon_word u_mon_word (
        .present     (mon_present),
        .ext_present (EXT_PRESENT),
        .capt        (CAPT[inst_idx]),
        .long_ctr    (LONG_CTR[inst_idx]),
        .wide_sel    (WIDE_SEL[inst_idx]),
        .rwbw        (RWBW[inst_idx]),
        .lnkg        (LNKG[inst_idx]),
        .ofsr        (OFSR[inst_idx]),
        .cevnt       (CEVNT[inst_idx]),
        .ofcapt      (OFCAPT[inst_idx]),
        .scale       (SCALE[inst_idx*5 +: 5]),
        .count       (MON_COUNT[slot_idx*16 +: 16]),
        .word        (mon_word)
    );

    // ==========================================================
    // per-space partition word, reserved bits masked
    logic [31:0] part_word;

    assign part_word = inst_ok ? (PART_WORD[slot_idx*32 +: 32] & BWID_PART_VALID_MASK)
                               : 32'h0000_0000;

    // ==========================================================
    // read port: next values
    logic [31:0] next_rd_data;
    logic        next_rd_ack;
    logic        next_wr_ack;

    // writes are acknowledged but store nothing; unmapped offsets read zero
    always_comb begin
        next_rd_data = BWID_RDATA_RST;
        next_rd_ack  = 1'b0;
        next_wr_ack  = wr_req;
        if (rd_req) begin
            next_rd_ack = 1'b1;
            if (ofs_hit(addr, BWID_PART_FEAT_OFS)) begin
                next_rd_data = part_word;
            end else if (ofs_hit(addr, BWID_MON_FEAT_OFS)) begin
                next_rd_data = mon_word;
            end
        end
    end

    // ==========================================================
    // read port: registers, frozen while ce is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= BWID_RDATA_RST;
            rd_ack  <= 1'b0;
            wr_ack  <= 1'b0;
        end else if (ce) begin
            rd_data <= next_rd_data;
            rd_ack  <= next_rd_ack;
            wr_ack  <= next_wr_ack;
        end
    end

endmodule : bwid_feature_regs
`default_nettype wire

// File: verif/bwid_feature_regs_props.sv
// checker on the read and write ports of the feature register bank
`timescale 1ns/1ps
`default_nettype none
module bwid_feature_regs_props
    import bwid_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              ce,
    input wire logic              rd_req,
    input wire logic              wr_req,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0]       rd_data,
    input wire logic              rd_ack,
    input wire logic              wr_ack
);
    // ==========================================================
    // request shapes
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd; ce && rd_req; endsequence
    sequence s_mon; s_rd ##0 addr == BWID_MON_FEAT_OFS; endsequence
    sequence s_part; s_rd ##0 addr == BWID_PART_FEAT_OFS; endsequence
    // ==========================================================
    // answers one enabled cycle after each request
    property p_ack; s_rd |=> rd_ack; endproperty
    a_ack: assert property (p_ack) else $error("read not acknowledged");
    property p_idle; ce && !rd_req |=> !rd_ack && rd_data == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read answer outlived its cycle");
    property p_wack; ce && wr_req |=> wr_ack; endproperty
    a_wack: assert property (p_wack) else $error("write not acknowledged");
    property p_nowack; ce && !wr_req |=> !wr_ack; endproperty
    a_nowack: assert property (p_nowack) else $error("stray write acknowledge");
    // frozen read data and read acknowledge while the clock enable is low
    property p_freeze; !ce |=> $stable(rd_data) && $stable(rd_ack); endproperty
    a_freeze: assert property (p_freeze) else $error("output moved while frozen");
    // ==========================================================
    // field rules of the returned words
    property p_wsel; s_mon |=> !(rd_data[BWID_WSEL_BIT] && !rd_data[BWID_LONG_BIT]); endproperty
    a_wsel: assert property (p_wsel) else $error("width select without wide counter");
    property p_resv; s_mon |=> rd_data[23:21] == 3'h0; endproperty
    a_resv: assert property (p_resv) else $error("monitor word reserved bits set");
    property p_pmask; s_part |=> (rd_data & ~BWID_PART_VALID_MASK) == 32'h0; endproperty
    a_pmask: assert property (p_pmask) else $error("partition word reserved bits set");
    property p_unmap;
        s_rd ##0 (addr != BWID_PART_FEAT_OFS && addr != BWID_MON_FEAT_OFS) |=> rd_data == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped offset read nonzero");
endmodule : bwid_feature_regs_props
`default_nettype wire

// File: verif/bwid_feature_regs_bench.sv
// self-checking bench for the feature register bank
`timescale 1ns/1ps
`default_nettype none
module bwid_feature_regs_bench
    import bwid_pkg::*;
;
    // ==========================================================
    // three instances, the last without usage monitoring
    localparam int             N  = 3;
    localparam logic [N-1:0]   CP = 3'b011, LG = 3'b101, LW = 3'b011, RW = 3'b001, LK = 3'b010;
    localparam logic [N-1:0]   OF = 3'b001, CV = 3'b010, OC = 3'b001, MB = 3'b011;
    localparam logic [14:0]    SC = {5'h00, 5'h1f, 5'h00};
    localparam logic [191:0]   MC = {96'h000c_000b_000a_0009_0008_0007,
                                     96'h0006_0005_0004_0003_0002_0001};
    localparam logic [383:0]   PW = {6{32'hffff_ffff, 32'h0000_1c05}};
    logic         clk = 0, sys_rst = 1, ce = 1, rd_req = 0, wr_req = 0, rd_ack, wr_ack, en;
    logic [1:0]   space = 0, sel = 0;
    logic [15:0]  addr = 0;
    logic [31:0]  wr_data = 0, rd_data, r;
    logic         rd_ack2, wr_ack2;
    logic [31:0]  rd_data2;
    logic [31:0]  expq[$], expq2[$];
    int           err_total = 0, num_checks = 0, wr_seen = 0, wr_sent = 0, wr_seen2 = 0;
    integer       seed = 65611;
    always #5 clk = ~clk;
    bwid_feature_regs #(.SEL_W(2), .NUM_INST(N), .SEL_PRESENT(1'b1), .MBWU_PRES(MB), .CAPT(CP),
        .LONG_CTR(LG), .WIDE_SEL(LW), .RWBW(RW), .LNKG(LK), .OFSR(OF), .CEVNT(CV), .OFCAPT(OC),
        .SCALE(SC), .MON_COUNT(MC), .PART_WORD(PW)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .ce(ce), .rd_req(rd_req), .wr_req(wr_req), .space(space), .addr(addr),
        .wr_data(wr_data), .resource_instance_selector(sel), .rd_data(rd_data),
        .rd_ack(rd_ack), .wr_ack(wr_ack));
    // same table without instance selection or extension: selector ignored, flags gated
    bwid_feature_regs #(.SEL_W(2), .NUM_INST(N), .SEL_PRESENT(1'b0), .EXT_PRESENT(1'b0),
        .MBWU_PRES(MB), .CAPT(CP), .LONG_CTR(LG), .WIDE_SEL(LW), .RWBW(RW), .LNKG(LK),
        .OFSR(OF), .CEVNT(CV), .OFCAPT(OC), .SCALE(SC), .MON_COUNT(MC), .PART_WORD(PW))
        dut2_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .rd_req(rd_req), .wr_req(wr_req),
        .space(space), .addr(addr), .wr_data(wr_data), .resource_instance_selector(sel),
        .rd_data(rd_data2), .rd_ack(rd_ack2), .wr_ack(wr_ack2));
    // ==========================================================
    // expected word, worked out from the bench's own feature table
    // x low: extension absent, so only bits 31 and 25 of the flag byte survive
    function automatic logic [31:0] exp_word(logic [1:0] s, logic [15:0] a, logic [1:0] i,
                                             logic x);
        int         k;
        logic [7:0] f;
        k = s * N + i;
        if (i >= N) return 32'h0;
        if (a == BWID_PART_FEAT_OFS) return PW[k*32 +: 32] & BWID_PART_VALID_MASK;
        if (a != BWID_MON_FEAT_OFS || !MB[i]) return 32'h0;
        f = {CP[i], LG[i] & x, LW[i] & LG[i] & x, RW[i] & x, LK[i] & x, OF[i] & x, CV[i],
             OC[i] & x};
        return {f, 3'h0, SC[i*5 +: 5], MC[k*16 +: 16]};
    endfunction : exp_word
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // drivers change inputs on the falling edge only
    task automatic rd(logic [1:0] s, logic [15:0] a, logic [1:0] i);
        @(negedge clk);
        rd_req = 1;
        wr_req = 0;
        space = s;
        addr = a;
        sel = i;
        expq.push_back(exp_word(s, a, i, 1'b1));
        expq2.push_back(exp_word(s, a, 2'h0, 1'b0));
    endtask : rd
    task automatic wr(logic [15:0] a);
        @(negedge clk);
        rd_req = 0;
        wr_req = 1;
        addr = a;
        wr_data = $random(seed);
        wr_sent++;
    endtask : wr
    task end_of_test;
        chk("write acks", 32'(wr_sent), 32'(wr_seen));
        chk("unanswered reads", 32'h0, 32'(expq.size()));
        chk("write acks 2", 32'(wr_sent), 32'(wr_seen2));
        chk("unanswered reads 2", 32'h0, 32'(expq2.size()));
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // monitor: a new answer lands only on an enabled edge
    always @(posedge clk) begin
        en = ce && !sys_rst;
        #1;
        if (en && rd_ack === 1'b1) begin
            if (expq.size() == 0) chk("stray read ack", 32'h1, 32'h0);
            else chk("rd_data", expq.pop_front(), rd_data);
        end
        if (en && rd_ack2 === 1'b1) begin
            if (expq2.size() == 0) chk("stray read ack 2", 32'h1, 32'h0);
            else chk("rd_data2", expq2.pop_front(), rd_data2);
        end
        if (en && wr_ack === 1'b1) wr_seen++;
        if (en && wr_ack2 === 1'b1) wr_seen2++;
    end
    initial begin
        #20000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        sys_rst = 0;
        chk("reset outputs", BWID_RDATA_RST, rd_data | {30'h0, rd_ack, wr_ack});
        // every frame, every selector incl. out of range, back to back
        for (int s = 0; s < 4; s++) for (int i = 0; i < 4; i++) begin
            rd(s[1:0], BWID_PART_FEAT_OFS, i[1:0]);
            rd(s[1:0], BWID_MON_FEAT_OFS, i[1:0]);
        end
        wr(BWID_PART_FEAT_OFS);
        wr(BWID_MON_FEAT_OFS);
        // random reads afterwards also prove the writes changed nothing
        repeat (40) begin
            r = $random(seed);
            rd(r[1:0], r[4] ? (r[5] ? BWID_MON_FEAT_OFS : BWID_PART_FEAT_OFS) : r[31:16],
               r[3:2]);
        end
        rd(2'h1, BWID_MON_FEAT_OFS, 2'h0);
        @(negedge clk);
        rd_req = 0;
        ce = 0;
        repeat (3) @(negedge clk);
        // the last answer must still stand while the enable is low
        chk("frozen rd_data", exp_word(2'h1, BWID_MON_FEAT_OFS, 2'h0, 1'b1), rd_data);
        chk("frozen rd_ack", 32'h1, 32'(rd_ack));
        ce = 1;
        @(negedge clk);
        // mid-run reset with a read held: nothing may be answered
        rd_req = 1;
        sys_rst = 1;
        repeat (2) @(negedge clk);
        chk("reset outputs 2", 32'h0,
            rd_data | rd_data2 | {28'h0, rd_ack, wr_ack, rd_ack2, wr_ack2});
        sys_rst = 0;
        rd_req = 0;
        // first read one cycle after the release
        rd(2'h3, BWID_PART_FEAT_OFS, 2'h2);
        @(negedge clk);
        rd_req = 0;
        repeat (4) @(negedge clk);
        end_of_test;
    end
endmodule : bwid_feature_regs_bench
bind bwid_feature_regs bwid_feature_regs_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk),
    .sys_rst(sys_rst), .ce(ce), .rd_req(rd_req), .wr_req(wr_req), .addr(addr),
    .rd_data(rd_data), .rd_ack(rd_ack), .wr_ack(wr_ack));
`default_nettype wire
